// ==== pscd_top.sv ====
`include "pscd_cfg.svh"

// Overview of operation
// - mode-select pin high puts that port in pin-only manual control.
// - mode-select pin low puts that port in management control.
// - management mode loads pin defaults, then management writes take effect.
// - manual mode ignores management writes to that port's registers.
// - strap pins are sampled while reset is held and set register values.
// - reset pin low, power-down low: stay in reset, latch pin defaults.
// - power-down high: low-power reset state whatever the other pins.
// - after reset or link-down, read control register before link bring-up.
// - forced speed and duplex start operating at once, no negotiation.
// - negotiation allowed starts auto-negotiation after reset or link-down.
// - media pin low gives 100 fiber, no negotiation, duplex from duplex pin.
// - twisted pair, all pins high: negotiate, advertise bits 8..5 all set.
// - negotiate, rate high, duplex low: advertise bits 8,7 only.
// - negotiate, rate low, duplex high: advertise bits 6,5 only.
// - negotiate, rate and duplex low: advertise bits 7,5 only.
// - twisted pair, negotiation low: force speed and duplex from pins.
// - decoded pins set defaults of control and advertisement registers.
module pscd_top import pscd_pkg::*; #(
  parameter int NPORT = `PSCD_NPORT,
  parameter int PW = $clog2(NPORT)
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic phy_reset_n_pin_i,
  input wire logic power_down_pin_i,
  input wire logic [NPORT-1:0] mgmt_write_disable_sel_i,
  input wire logic [NPORT-1:0] media_select_pin_i,
  input wire logic [NPORT-1:0] negotiation_enable_pin_i,
  input wire logic [NPORT-1:0] rate_select_pin_i,
  input wire logic [NPORT-1:0] full_half_select_pin_i,
  input wire logic [NPORT-1:0] link_down_i,
  input wire logic [PW+`PSCD_REGW-1:0] reg_addr_i,
  input wire logic [`PSCD_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`PSCD_DW-1:0] reg_rdata_o,
  output logic low_power_o,
  output logic in_reset_o,
  output logic [NPORT-1:0] port_manual_o,
  output logic [NPORT-1:0] port_forced_o,
  output logic [NPORT-1:0] port_aneg_o,
  output pscd_link_t [NPORT-1:0] port_link_o
);

  logic [1:0] chip_s;
  logic [5*NPORT-1:0] pin_s;
  logic pd_s;
  logic rst_n_s;
  logic hold;
  pscd_chip_st_t chip_st;
  pscd_chip_st_t next_chip;
  pscd_strap_t strap_s [NPORT];
  pscd_strap_t strap_q [NPORT];
  pscd_strap_t next_strap [NPORT];
  pscd_link_st_t lst [NPORT];
  pscd_link_st_t next_lst [NPORT];
  logic [`PSCD_DW-1:0] ctrl [NPORT];
  logic [`PSCD_DW-1:0] next_ctrl [NPORT];
  logic [`PSCD_DW-1:0] adv [NPORT];
  logic [`PSCD_DW-1:0] next_adv [NPORT];
  logic [NPORT-1:0] next_manual;
  logic [NPORT-1:0] next_forced;
  logic [NPORT-1:0] next_aneg;
  pscd_link_t [NPORT-1:0] next_link;
  logic [`PSCD_DW-1:0] next_rdata;

  // default control word decoded from the straps
  function automatic logic [`PSCD_DW-1:0] f_ctrl(input pscd_strap_t s);
    logic [`PSCD_DW-1:0] c;
    c = `PSCD_CTRL_RST;
    c[`PSCD_CTRL_SPEED] = !s.media || s.rate;
    c[`PSCD_CTRL_ANEG] = s.media && s.neg;
    c[`PSCD_CTRL_DUPLEX] = s.duplex;
    return c;
  endfunction : f_ctrl

  // default advertisement word; forced and fiber ports keep every ability
  function automatic logic [`PSCD_DW-1:0] f_adv(input pscd_strap_t s);
    logic [`PSCD_DW-1:0] a;
    a = `PSCD_ADV_RST;
    a[`PSCD_ADV_HI:`PSCD_ADV_LO] = `PSCD_ADV_ALL;
    if (s.media && s.neg) begin
      a[`PSCD_ADV_HI:`PSCD_ADV_LO] = {s.rate, s.rate || !s.duplex,
                                      s.duplex, !s.rate || s.duplex};
    end
    return a;
  endfunction : f_adv

  // board pins come from outside the clock domain
  pscd_sync #(.W(2), .RST(2'b00)) u_chip_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i({power_down_pin_i, phy_reset_n_pin_i}),
    .level_o(chip_s)
  );

  pscd_sync #(.W(5*NPORT), .RST('0)) u_strap_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i({mgmt_write_disable_sel_i, media_select_pin_i, negotiation_enable_pin_i,
            rate_select_pin_i, full_half_select_pin_i}),
    .level_o(pin_s)
  );

  assign pd_s = chip_s[1];
  assign rst_n_s = chip_s[0];
  assign hold = (chip_st != PSCD_ACTIVE);

  // unpack the strap vector per port
  for (genvar gp = 0; gp < NPORT; gp++) begin : g_unpack
    assign strap_s[gp] = {pin_s[3*NPORT+gp], pin_s[2*NPORT+gp], pin_s[NPORT+gp], pin_s[gp]};
  end

  // power-down outranks the reset pin, which outranks normal running
  always_comb begin
    next_chip = PSCD_ACTIVE;
    if (pd_s) begin
      next_chip = PSCD_PWR_DOWN;
    end else if (!rst_n_s) begin
      next_chip = PSCD_IN_RESET;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chip_st <= PSCD_IN_RESET;
      low_power_o <= 1'b0;
      in_reset_o <= 1'b1;
    end else begin
      chip_st <= next_chip;
      low_power_o <= (next_chip == PSCD_PWR_DOWN);
      in_reset_o <= (next_chip != PSCD_ACTIVE);
    end
  end

  // per-port straps, registers and link bring-up
  always_comb begin
    logic wr_hit;
    logic restart;
    wr_hit = 1'b0;
    restart = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      next_strap[p] = strap_q[p];
      next_manual[p] = port_manual_o[p];
      next_ctrl[p] = ctrl[p];
      next_adv[p] = adv[p];
      next_lst[p] = lst[p];
      next_forced[p] = port_forced_o[p];
      next_aneg[p] = port_aneg_o[p];
      next_link[p] = port_link_o[p];
      wr_hit = reg_wr_i && (reg_addr_i[PW+`PSCD_REGW-1:`PSCD_REGW] == PW'(p)) && !port_manual_o[p];
      restart = 1'b0;
      if (hold) begin
        // keep sampling while held so the last level before release wins
        next_strap[p] = strap_s[p];
        next_manual[p] = pin_s[4*NPORT+p];
        next_ctrl[p] = f_ctrl(strap_s[p]);
        next_adv[p] = f_adv(strap_s[p]);
        next_lst[p] = PSCD_LS_HOLD;
        next_forced[p] = 1'b0;
        next_aneg[p] = 1'b0;
      end else begin
        if (wr_hit && reg_addr_i[`PSCD_REGW-1:0] == `PSCD_REG_CTRL) begin
          next_ctrl[p] = reg_wdata_i & `PSCD_CTRL_WMASK;
          restart = reg_wdata_i[`PSCD_CTRL_RESTART];
        end else if (wr_hit && reg_addr_i[`PSCD_REGW-1:0] == `PSCD_REG_ADV) begin
          next_adv[p] = (reg_wdata_i & `PSCD_ADV_WMASK) | `PSCD_ADV_RST;
        end
        case (lst[p])
          PSCD_LS_HOLD: begin
            next_lst[p] = PSCD_LS_CHECK;
          end
          PSCD_LS_CHECK: begin
            // the control register sets speed, duplex and negotiation, whether pins or software filled it; a fiber strap blocks negotiation
            next_link[p] = '{fiber: !strap_q[p].media,
                             aneg: ctrl[p][`PSCD_CTRL_ANEG] && strap_q[p].media,
                             speed100: ctrl[p][`PSCD_CTRL_SPEED],
                             full: ctrl[p][`PSCD_CTRL_DUPLEX]};
            if (ctrl[p][`PSCD_CTRL_ANEG] && strap_q[p].media) begin
              next_lst[p] = PSCD_LS_ANEG;
              next_aneg[p] = 1'b1;
            end else begin
              next_lst[p] = PSCD_LS_FORCED;
              next_forced[p] = 1'b1;
            end
          end
          default: begin
            if (link_down_i[p] || restart) begin
              next_lst[p] = PSCD_LS_CHECK;
              next_forced[p] = 1'b0;
              next_aneg[p] = 1'b0;
            end
          end
        endcase
      end
    end
  end

  // straps and mode change only under hold, so they stay put while running
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      port_manual_o <= '0;
      port_forced_o <= '0;
      port_aneg_o <= '0;
      port_link_o <= '0;
      for (int p = 0; p < NPORT; p++) begin
        strap_q[p] <= '0;
        ctrl[p] <= `PSCD_CTRL_RST;
        adv[p] <= `PSCD_ADV_RST;
        lst[p] <= PSCD_LS_HOLD;
      end
    end else begin
      port_manual_o <= next_manual;
      port_forced_o <= next_forced;
      port_aneg_o <= next_aneg;
      port_link_o <= next_link;
      for (int p = 0; p < NPORT; p++) begin
        strap_q[p] <= next_strap[p];
        ctrl[p] <= next_ctrl[p];
        adv[p] <= next_adv[p];
        lst[p] <= next_lst[p];
      end
    end
  end

  // read data stand for exactly one cycle; unmapped numbers read zero
  always_comb begin
    logic [PW-1:0] pi;
    pi = reg_addr_i[PW+`PSCD_REGW-1:`PSCD_REGW];
    next_rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i[`PSCD_REGW-1:0] == `PSCD_REG_CTRL) begin
        next_rdata = ctrl[pi];
      end else if (reg_addr_i[`PSCD_REGW-1:0] == `PSCD_REG_ADV) begin
        next_rdata = adv[pi];
      end else if (reg_addr_i[`PSCD_REGW-1:0] == `PSCD_REG_STAT) begin
        next_rdata = {10'h000, low_power_o, hold, port_aneg_o[pi], port_forced_o[pi],
                      !strap_q[pi].media, port_manual_o[pi]};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_PWR_DOWN: assert property (pd_s |=> chip_st == PSCD_PWR_DOWN && low_power_o)
    else $error("power-down pin did not force low-power state");
  AST_RESET_HOLD: assert property (!pd_s && !rst_n_s |=> chip_st == PSCD_IN_RESET && in_reset_o)
    else $error("reset pin low did not hold the device in reset");

  for (genvar gp = 0; gp < NPORT; gp++) begin : g_ast
    sequence s_release;
      hold ##1 !hold;
    endsequence
    sequence s_check;
      lst[gp] == PSCD_LS_CHECK;
    endsequence
    AST_MANUAL: assert property (hold && pin_s[4*NPORT+gp] ##1 !hold |-> port_manual_o[gp])
      else $error("select high did not give manual mode");
    AST_MGMT: assert property (hold && !pin_s[4*NPORT+gp] ##1 !hold |-> !port_manual_o[gp])
      else $error("select low did not give management mode");
    AST_MGMT_WRITE: assert property (!hold && !port_manual_o[gp] && reg_wr_i
        && reg_addr_i == {PW'(gp), `PSCD_REG_CTRL}
        |=> ctrl[gp] == ($past(reg_wdata_i) & `PSCD_CTRL_WMASK))
      else $error("management write to control register lost");
    AST_MANUAL_NOWRITE: assert property (!hold && port_manual_o[gp] && reg_wr_i
        && reg_addr_i[PW+`PSCD_REGW-1:`PSCD_REGW] == PW'(gp)
        |=> ctrl[gp] == $past(ctrl[gp]) && adv[gp] == $past(adv[gp]))
      else $error("manual port accepted a management write");
    AST_SAMPLE: assert property (hold |=> strap_q[gp] == $past(strap_s[gp]))
      else $error("straps not sampled during reset");
    AST_CHECK_FIRST: assert property (s_release |=> s_check)
      else $error("link bring-up did not read control register first");
    AST_FORCED: assert property (s_check and (!hold && (!ctrl[gp][`PSCD_CTRL_ANEG] || !strap_q[gp].media))
        |=> lst[gp] == PSCD_LS_FORCED && port_forced_o[gp] && !port_aneg_o[gp])
      else $error("forced mode not started at once");
    AST_ANEG: assert property (s_check and (!hold && ctrl[gp][`PSCD_CTRL_ANEG] && strap_q[gp].media)
        |=> lst[gp] == PSCD_LS_ANEG && port_aneg_o[gp])
      else $error("negotiation not started");
    AST_FIBER: assert property (hold && !strap_s[gp].media |=> !ctrl[gp][`PSCD_CTRL_ANEG]
        && ctrl[gp][`PSCD_CTRL_SPEED] && ctrl[gp][`PSCD_CTRL_DUPLEX] == $past(strap_s[gp].duplex))
      else $error("fiber default wrong");
    AST_ADV_ALL: assert property (hold && strap_s[gp] == 4'hf |=> adv[gp][8:5] == 4'hf)
      else $error("all abilities not advertised");
    AST_ADV_100: assert property (hold && strap_s[gp] == 4'he |=> adv[gp][8:5] == 4'hc)
      else $error("100 only advertisement wrong");
    AST_ADV_10: assert property (hold && strap_s[gp] == 4'hd |=> adv[gp][8:5] == 4'h3)
      else $error("10 only advertisement wrong");
    AST_ADV_HALF: assert property (hold && strap_s[gp] == 4'hc |=> adv[gp][8:5] == 4'h5)
      else $error("half only advertisement wrong");
    AST_TP_FORCED: assert property (hold && strap_s[gp].media && !strap_s[gp].neg
        |=> !ctrl[gp][`PSCD_CTRL_ANEG] && ctrl[gp][`PSCD_CTRL_SPEED] == $past(strap_s[gp].rate)
        && ctrl[gp][`PSCD_CTRL_DUPLEX] == $past(strap_s[gp].duplex))
      else $error("forced twisted pair default wrong");
    AST_DEFAULTS: assert property (hold |=> ctrl[gp] == f_ctrl($past(strap_s[gp]))
        && adv[gp] == f_adv($past(strap_s[gp])))
      else $error("register defaults not loaded from straps");
    AST_STABLE: assert property (!hold ##1 !hold |-> $stable(port_manual_o[gp]) && $stable(strap_q[gp]))
      else $error("strap capture changed while running");
  end

endmodule : pscd_top

// ==== pscd_cfg.svh ====
`ifndef PSCD_CFG_SVH
`define PSCD_CFG_SVH

// geometry
`define PSCD_NPORT 2
`define PSCD_REGW 5
`define PSCD_DW 16

// register numbers inside one port
`define PSCD_REG_CTRL 5'h00
`define PSCD_REG_ADV 5'h04
`define PSCD_REG_STAT 5'h10

// basic control register fields
`define PSCD_CTRL_SPEED 13
`define PSCD_CTRL_ANEG 12
`define PSCD_CTRL_RESTART 9
`define PSCD_CTRL_DUPLEX 8
`define PSCD_CTRL_WMASK 16'h3100
`define PSCD_CTRL_RST 16'h0000

// advertisement register fields
`define PSCD_ADV_HI 8
`define PSCD_ADV_LO 5
`define PSCD_ADV_WMASK 16'h01e0
`define PSCD_ADV_RST 16'h0001
`define PSCD_ADV_ALL 4'hf

// pin synchroniser depth
`define PSCD_SYNC_STAGES 3

`endif

// ==== pscd_pkg.sv ====
package pscd_pkg;

  // strap levels of one port as sampled in reset
  typedef struct packed {
    logic media;
    logic neg;
    logic rate;
    logic duplex;
  } pscd_strap_t;

  // operating point handed to the link logic
  typedef struct packed {
    logic fiber;
    logic aneg;
    logic speed100;
    logic full;
  } pscd_link_t;

  typedef enum logic [2:0] {
    PSCD_PWR_DOWN = 3'b001,
    PSCD_IN_RESET = 3'b010,
    PSCD_ACTIVE = 3'b100
  } pscd_chip_st_t;

  typedef enum logic [3:0] {
    PSCD_LS_HOLD = 4'b0001,
    PSCD_LS_CHECK = 4'b0010,
    PSCD_LS_FORCED = 4'b0100,
    PSCD_LS_ANEG = 4'b1000
  } pscd_link_st_t;

endpackage : pscd_pkg

// ==== pscd_sync.sv ====
`include "pscd_cfg.svh"

module pscd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // a bit moves only when stages two and three agree, so a glitch caught once is dropped
  always_comb begin
    next_level = (s3 & ~(s2 ^ s3)) | (level_o & (s2 ^ s3));
  end

  // s1 is read by s2 only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
      level_o <= RST;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= next_level;
    end
  end

endmodule : pscd_sync

// ==== pscd_board.sv ====
module pscd_board import pscd_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rst_n_req_i,
  input wire logic pdn_req_i,
  input wire logic [1:0] sel_req_i,
  input wire pscd_strap_t [1:0] strap_req_i,
  output logic phy_reset_n_pin_o,
  output logic power_down_pin_o,
  output logic [1:0] sel_o,
  output logic [1:0] media_o,
  output logic [1:0] neg_o,
  output logic [1:0] rate_o,
  output logic [1:0] dup_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // jumpers are static levels; a requested change lands one edge late, unrelated to device state
  // pins settle at the first edge, while the device logic is still in its own reset
  always @(posedge ref_clk_i) begin
    phy_reset_n_pin_o <= rst_n_req_i;
    power_down_pin_o <= pdn_req_i;
    sel_o <= sel_req_i;
    for (int p = 0; p < 2; p++) begin
      media_o[p] <= strap_req_i[p].media;
      neg_o[p] <= strap_req_i[p].neg;
      rate_o[p] <= strap_req_i[p].rate;
      dup_o[p] <= strap_req_i[p].duplex;
    end
  end
endmodule : pscd_board

// ==== phy_port_strap_config_decode_tb.sv ====
module phy_port_strap_config_decode_tb import pscd_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rst_n_req = 1'b0;
  logic pdn_req = 1'b0;
  logic [1:0] sel_req = 2'b00;
  pscd_strap_t [1:0] strap_req = '0;
  logic [1:0] link_down = 2'b00;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic phy_rst_n, pdn, low_power, in_reset;
  logic [1:0] sel, media, neg, rate, dup, manual, forced, aneg;
  logic [15:0] rdata;
  pscd_link_t [1:0] link;
  int err_count = 0;
  int tests_run = 0;
  integer seed = 32'h809b365f;

  // 50 MHz
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  pscd_board board_u (.ref_clk_i(ref_clk_i), .rst_n_req_i(rst_n_req), .pdn_req_i(pdn_req), .sel_req_i(sel_req),
    .strap_req_i(strap_req), .phy_reset_n_pin_o(phy_rst_n), .power_down_pin_o(pdn), .sel_o(sel),
    .media_o(media), .neg_o(neg), .rate_o(rate), .dup_o(dup));

  pscd_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .phy_reset_n_pin_i(phy_rst_n), .power_down_pin_i(pdn),
    .mgmt_write_disable_sel_i(sel), .media_select_pin_i(media), .negotiation_enable_pin_i(neg),
    .rate_select_pin_i(rate), .full_half_select_pin_i(dup), .link_down_i(link_down), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .low_power_o(low_power),
    .in_reset_o(in_reset), .port_manual_o(manual), .port_forced_o(forced), .port_aneg_o(aneg),
    .port_link_o(link));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // bounded wait until a port runs forced or negotiating
  task automatic wait_up(input int p);
    int n;
    n = 0;
    while (!(forced[p] === 1'b1 || aneg[p] === 1'b1)) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if (n > 40) begin
        err_count++;
        $display("MISMATCH port_up expected 1 seen 0");
        summarize();
      end
    end
  endtask : wait_up

  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : bus_wr

  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  function automatic logic [15:0] exp_adv(input pscd_strap_t s);
    logic [3:0] a;
    a = 4'hf;
    if (s.media && s.neg) begin
      case ({s.rate, s.duplex})
        2'b10: a = 4'hc;
        2'b01: a = 4'h3;
        2'b00: a = 4'h5;
        default: a = 4'hf;
      endcase
    end
    return {7'h00, a, 5'h01};
  endfunction : exp_adv

  // speed and duplex bits are only pinned down for forced straps
  function automatic logic [15:0] exp_ctrl(input pscd_strap_t s);
    if (s.media && s.neg) return 16'h1000;
    return {2'b00, ~s.media | s.rate, 4'h0, s.duplex, 8'h00};
  endfunction : exp_ctrl

  task automatic check_port(input int p, input pscd_strap_t s, input logic [15:0] adv);
    logic [15:0] d;
    logic [15:0] m;
    logic [15:0] lm;
    logic an;
    an = s.media & s.neg;
    m = an ? 16'h1000 : 16'hffff;
    lm = an ? 16'h000c : 16'h000f;
    bus_rd({p[0], 5'h00}, d);
    chk("ctrl", d & m, exp_ctrl(s) & m);
    bus_rd({p[0], 5'h04}, d);
    chk("adv", d, adv);
    chk("aneg_run", {15'h0, aneg[p]}, {15'h0, an});
    chk("forced_run", {15'h0, forced[p]}, {15'h0, ~an});
    chk("link", {12'h0, link[p]} & lm, {12'h0, ~s.media, an, ~s.media | s.rate, s.duplex} & lm);
  endtask : check_port

  // hold the reset pin low with new straps, check the held state, then release
  task automatic boot(input pscd_strap_t s0, input pscd_strap_t s1, input logic [1:0] m);
    @(posedge ref_clk_i);
    rst_n_req <= 1'b0;
    strap_req <= {s1, s0};
    sel_req <= m;
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk("held", {13'h0, in_reset, forced | aneg}, 16'h0004);
    rst_n_req <= 1'b1;
    wait_up(0);
    wait_up(1);
  endtask : boot

  // every strap combination on port 0, random straps and modes on port 1
  initial begin
    pscd_strap_t s[2];
    logic [1:0] m;
    logic [15:0] adv[2];
    logic [15:0] d;
    logic [15:0] w;
    int p;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      w = 16'($random(seed));
      s[0] = i[3:0];
      s[1] = w[3:0];
      m = (i < 2) ? {i[0], i[0]} : w[5:4];
      boot(s[0], s[1], m);
      chk("manual", {14'h0, manual}, {14'h0, m});
      strap_req <= ~{s[1], s[0]};
      repeat (6) @(posedge ref_clk_i);
      for (p = 0; p < 2; p++) begin
        adv[p] = exp_adv(s[p]);
        check_port(p, s[p], adv[p]);
        w = 16'($random(seed));
        bus_wr({p[0], 5'h04}, w);
        if (!m[p]) adv[p] = {7'h00, w[8:5], 5'h01};
        bus_rd({p[0], 5'h04}, d);
        chk("adv_wr", d, adv[p]);
      end
      // forced 100 full written, taken up only at link-down
      p = i % 2;
      bus_wr({p[0], 5'h00}, 16'h2100);
      @(posedge ref_clk_i);
      link_down[p] <= 1'b1;
      @(posedge ref_clk_i);
      link_down[p] <= 1'b0;
      #1;
      chk("mode_drop", {14'h0, forced[p], aneg[p]}, 16'h0);
      wait_up(p);
      if (!m[p]) begin
        chk("forced_wr", {14'h0, forced[p], aneg[p]}, 16'h0002);
        // restart with negotiation requested; fiber straps still keep it forced
        bus_wr({p[0], 5'h00}, 16'h1200);
        #1;
        chk("restart_drop", {14'h0, forced[p], aneg[p]}, 16'h0);
        wait_up(p);
        chk("restart_up", {14'h0, forced[p], aneg[p]}, {14'h0, ~s[p].media, s[p].media});
      end else begin
        check_port(p, s[p], adv[p]);
      end
    end
    // power-down with the reset pin high; straps still latched, writes dropped
    w = 16'($random(seed));
    s[0] = w[3:0];
    s[1] = w[7:4];
    @(posedge ref_clk_i);
    pdn_req <= 1'b1;
    strap_req <= {s[1], s[0]};
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk("low_power", {13'h0, low_power, in_reset, |(forced | aneg)}, 16'h0006);
    bus_wr(6'h04, 16'h0000);
    bus_rd(6'h10, d);
    chk("status", d, {10'h000, 2'b11, 2'b00, ~s[0].media, m[0]});
    pdn_req <= 1'b0;
    wait_up(0);
    wait_up(1);
    chk("low_power_off", {15'h0, low_power}, 16'h0);
    check_port(0, s[0], exp_adv(s[0]));
    bus_rd(6'h1f, d);
    chk("unmapped", d, 16'h0);
    summarize();
  end
endmodule : phy_port_strap_config_decode_tb
